// File: rtl/sdi_pkg.sv
// Constants and register map for the serial DAC input interface
// What this block does
// - Shift one bit per falling link clock edge
// - Frame select high restarts the transfer logic
// - Strobed mode loads latch on strobe fall
// - Strobe held low loads on 16th edge
// - Chain mode drives serial output, shifts out
// - Clear forces latch to all-zeros code
// - Format select picks binary or twos complement
// - Bipolar zero code depends on coding format
// - Ignore first four bits, latch last twelve
// - Standalone mode accepts exactly 16 edges
// - Mode sampled at frame start; strobe high between
package sdi_pkg;
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [DATA_BITS-1:0] CLEAR_CODE = 12'h000;
  localparam logic [DATA_BITS-1:0] ZERO_TWOS = 12'h000;
  localparam logic [DATA_BITS-1:0] ZERO_OFFSET = 12'h800;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ZERO = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  // Field positions
  localparam int CTRL_SOFT_CLR = 0;
  localparam int ST_FMT = 12;
  localparam int ST_CHAIN = 13;
  localparam int ST_AUTO = 14;
  localparam int ST_CLR = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchronised input lanes
  localparam int IX_LOAD_LATCH_N = 0;
  localparam int IX_CLR = 1;
  localparam int IX_FMT = 2;
  localparam int IX_CHAIN = 3;
  localparam int IX_AUTO = 4;
  localparam int IX_TGL = 5;
  localparam int NSYNC = 6;
  localparam logic [NSYNC-1:0] SYNC_RST = 6'h03;
endpackage

// File: rtl/sdi_dac_input.sv
// Serial DAC input logic with AXI4-Lite status and control
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sdi_dac_input
  import sdi_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Core clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic CE,
  // Serial link pins
  input wire logic LINK_CLK,
  input wire logic FRAME_N,
  input wire logic SERIAL_DATA_IN,
  input wire logic LOAD_LATCH_N,
  input wire logic CHAIN_MODE_ENABLE,
  input wire logic CLEAR_N,
  input wire logic FORMAT_SELECT,
  output var logic SERIAL_DATA_OUT,
  output var logic SERIAL_DATA_OUT_OE_N,
  // Parallel outputs to the converter
  output var logic [DATA_BITS-1:0] DAC_CODE,
  output var logic DAC_FORMAT,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output var logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output var logic S_AXI_WREADY,
  // AXI4-Lite write response
  output var logic [1:0] S_AXI_BRESP,
  output var logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output var logic S_AXI_ARREADY,
  output var logic [31:0] S_AXI_RDATA,
  output var logic [1:0] S_AXI_RRESP,
  output var logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Zero-output code for the chosen coding
  function automatic logic [DATA_BITS-1:0] zero_code(input logic fmt);
    zero_code = fmt ? ZERO_TWOS : ZERO_OFFSET;
  endfunction

  // Filter: take new value once second and third stages agree
  function automatic logic [NSYNC-1:0] agree(input logic [NSYNC-1:0] s2,
    input logic [NSYNC-1:0] s3, input logic [NSYNC-1:0] q);
    agree = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
  endfunction

  // ---------------- Link domain (falling edges) ----------------
  logic [CNT_W-1:0] bit_cnt_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [DATA_BITS-1:0] word_lk_r;
  logic auto_r;
  logic load_tgl_r;
  logic shift_en;
  logic auto_now;

  // Gate: open during the frame, closed after 16 bits unless chained
  assign shift_en = !FRAME_N && (CHAIN_MODE_ENABLE || bit_cnt_r != CNT_FULL);
  // Mode decided from the strobe level at the first edge of a frame
  assign auto_now = (bit_cnt_r == CNT_ZERO) ? !LOAD_LATCH_N : auto_r;

  // Bit counter, held clear while frame select is high
  always_ff @(negedge LINK_CLK or posedge FRAME_N)
  begin
    if (FRAME_N)
    begin
      bit_cnt_r <= CNT_ZERO;
    end
    else if (shift_en && bit_cnt_r != CNT_FULL)
    begin
      bit_cnt_r <= bit_cnt_r + CNT_ONE;
    end
  end

  // Input shift register; its top bit feeds the chain output
  always_ff @(negedge LINK_CLK or posedge SRST)
  begin
    if (SRST)
    begin
      shift_r <= '0;
    end
    else if (shift_en)
    begin
      shift_r <= {shift_r[WORD_BITS-2:0], SERIAL_DATA_IN};
    end
  end

  // Update mode capture at frame start
  always_ff @(negedge LINK_CLK or posedge SRST)
  begin
    if (SRST)
    begin
      auto_r <= 1'b0;
    end
    else if (shift_en && bit_cnt_r == CNT_ZERO)
    begin
      auto_r <= !LOAD_LATCH_N;
    end
  end

  // Automatic update: hold last 12 bits, flag core with a toggle
  always_ff @(negedge LINK_CLK or posedge SRST)
  begin
    if (SRST)
    begin
      word_lk_r <= CLEAR_CODE;
      load_tgl_r <= 1'b0;
    end
    else if (shift_en && bit_cnt_r == CNT_LAST && auto_now)
    begin
      word_lk_r <= {shift_r[DATA_BITS-2:0], SERIAL_DATA_IN};
      load_tgl_r <= !load_tgl_r;
    end
  end

  assign SERIAL_DATA_OUT = shift_r[WORD_BITS-1];

  // ---------------- Core domain ----------------
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] pin_q_r;
  logic [NSYNC-1:0] pin_q_nxt;
  logic load_latch_n_fall;
  logic tgl_evt;
  // Events wait until the filter holds real pin levels, so the
  // reset value of a lane never reads as a false edge
  localparam int SETTLE = 4;
  logic [SETTLE-1:0] prime_r;
  logic armed;
  logic clear_act;
  logic [DATA_BITS-1:0] latch_r;
  logic oe_n_r;
  logic [31:0] ctrl_r;
  logic [15:0] count_r;

  assign sync_in[IX_LOAD_LATCH_N] = LOAD_LATCH_N;
  assign sync_in[IX_CLR] = CLEAR_N;
  assign sync_in[IX_FMT] = FORMAT_SELECT;
  assign sync_in[IX_CHAIN] = CHAIN_MODE_ENABLE;
  assign sync_in[IX_AUTO] = auto_r;
  assign sync_in[IX_TGL] = load_tgl_r;
  assign pin_q_nxt = agree(s2_r, s3_r, pin_q_r);

  // Three-stage synchroniser and agreement filter
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
      pin_q_r <= SYNC_RST;
      prime_r <= '0;
    end
    else if (CE)
    begin
      prime_r <= {prime_r[SETTLE-2:0], 1'b1};
      s1_r <= sync_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_q_r <= pin_q_nxt;
    end
  end

  // Events seen on the filtered levels
  assign armed = prime_r[SETTLE-1];
  assign load_latch_n_fall = armed && pin_q_r[IX_LOAD_LATCH_N] && !pin_q_nxt[IX_LOAD_LATCH_N];
  assign tgl_evt = armed && (pin_q_r[IX_TGL] ^ pin_q_nxt[IX_TGL]);
  assign clear_act = !pin_q_r[IX_CLR] || ctrl_r[CTRL_SOFT_CLR];

  // DAC latch; clear wins, then auto update, then strobe.
  // Shift register is still while frame select is high, so the
  // strobe copy reads it without a handshake.
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      latch_r <= CLEAR_CODE;
    end
    else if (CE)
    begin
      if (clear_act)
      begin
        latch_r <= CLEAR_CODE;
      end
      else if (tgl_evt)
      begin
        latch_r <= word_lk_r;
      end
      else if (load_latch_n_fall)
      begin
        latch_r <= shift_r[DATA_BITS-1:0];
      end
    end
  end

  // Count of latch updates for software
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      count_r <= COUNT_RST;
    end
    else if (CE && !clear_act && (tgl_evt || load_latch_n_fall))
    begin
      count_r <= count_r + COUNT_ONE;
    end
  end

  // Chain output enable follows the strapped level
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      oe_n_r <= 1'b1;
    end
    else if (CE)
    begin
      oe_n_r <= !pin_q_r[IX_CHAIN];
    end
  end

  assign SERIAL_DATA_OUT_OE_N = oe_n_r;
  assign DAC_CODE = latch_r;
  assign DAC_FORMAT = pin_q_r[IX_FMT];

  // ---------------- AXI4-Lite slave ----------------
  logic aw_got_r;
  logic w_got_r;
  logic awready_r;
  logic wready_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [7:0] wofs;
  logic [7:0] rofs;
  logic [31:0] rd_val;
  logic rd_ok;

  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign wofs = 8'(awaddr_r);
  assign rofs = 8'(S_AXI_ARADDR);

  // Write address capture
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      aw_got_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r <= '0;
    end
    else if (CE)
    begin
      if (S_AXI_AWVALID && !aw_got_r)
      begin
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= S_AXI_AWADDR;
      end
      else if (do_write)
      begin
        aw_got_r <= 1'b0;
        awready_r <= 1'b1;
      end
    end
  end

  // Write data capture
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      w_got_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (CE)
    begin
      if (S_AXI_WVALID && !w_got_r)
      begin
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      else if (do_write)
      begin
        w_got_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // Ready flags are registered copies of the free capture slots
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;

  // Register write and response
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      ctrl_r <= CTRL_RST;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (CE)
    begin
      if (do_write)
      begin
        bvalid_r <= 1'b1;
        if (wofs == OFS_CTRL)
        begin
          if (wstrb_r[0])
          begin
            ctrl_r[CTRL_SOFT_CLR] <= wdata_r[CTRL_SOFT_CLR];
          end
          bresp_r <= RESP_OKAY;
        end
        else if (wofs == OFS_STATUS || wofs == OFS_ZERO || wofs == OFS_COUNT)
        begin
          bresp_r <= RESP_OKAY;
        end
        else
        begin
          bresp_r <= RESP_SLVERR;
        end
      end
      else if (S_AXI_BREADY)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  // Read decode
  always_comb
  begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (rofs == OFS_CTRL)
    begin
      rd_val = ctrl_r;
    end
    else if (rofs == OFS_STATUS)
    begin
      rd_val[DATA_BITS-1:0] = latch_r;
      rd_val[ST_FMT] = pin_q_r[IX_FMT];
      rd_val[ST_CHAIN] = pin_q_r[IX_CHAIN];
      rd_val[ST_AUTO] = pin_q_r[IX_AUTO];
      rd_val[ST_CLR] = clear_act;
    end
    else if (rofs == OFS_ZERO)
    begin
      rd_val[DATA_BITS-1:0] = zero_code(pin_q_r[IX_FMT]);
    end
    else if (rofs == OFS_COUNT)
    begin
      rd_val[15:0] = count_r;
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (CE)
    begin
      if (S_AXI_ARVALID && arready_r)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && S_AXI_RREADY)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

endmodule
`default_nettype wire

// File: test/sdi_dac_input_assertions.sv
// Port-level checker for the serial DAC input logic
`timescale 1ns/100ps
`default_nettype none
module sdi_dac_input_assertions
  import sdi_pkg::*;
(
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link side levels
  input wire logic FRAME_N,
  input wire logic LOAD_LATCH_N,
  input wire logic CHAIN_MODE_ENABLE,
  input wire logic CLEAR_N,
  input wire logic FORMAT_SELECT,
  input wire logic SERIAL_DATA_OUT_OE_N,
  // Converter outputs
  input wire logic [DATA_BITS-1:0] DAC_CODE,
  input wire logic DAC_FORMAT,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Bus handshakes
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  // Link levels reach the outputs after synchronising
  clear_zero_a: assert property ((!CLEAR_N)[*8] |-> DAC_CODE == CLEAR_CODE)
    else $error("clear did not zero code");
  oe_chain_a: assert property ($stable(CHAIN_MODE_ENABLE)[*8] |->
    SERIAL_DATA_OUT_OE_N == !CHAIN_MODE_ENABLE) else $error("oe_n wrong");
  format_out_a: assert property ($stable(FORMAT_SELECT)[*8] |->
    DAC_FORMAT == FORMAT_SELECT) else $error("format wrong");
  code_holds_a: assert property ((FRAME_N && LOAD_LATCH_N && CLEAR_N)[*8] |->
    $stable(DAC_CODE)) else $error("code moved while idle");
  reset_state_a: assert property ($fell(SRST) |-> SERIAL_DATA_OUT_OE_N &&
    DAC_CODE == CLEAR_CODE && !S_AXI_RVALID) else $error("reset state wrong");
  // Register bus timing
  write_resp_a: assert property (s_wr |-> ##2 S_AXI_BVALID)
    else $error("no write response");
  read_resp_a: assert property (s_rd |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("no read response");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
endmodule
bind sdi_dac_input sdi_dac_input_assertions chk (.CORE_CLK, .SRST, .FRAME_N,
  .LOAD_LATCH_N, .CHAIN_MODE_ENABLE, .CLEAR_N, .FORMAT_SELECT, .SERIAL_DATA_OUT_OE_N,
  .DAC_CODE, .DAC_FORMAT, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY);
`default_nettype wire

// File: test/sdi_host_model.sv
// Host serial port model for the link side
`timescale 1ns/100ps
`default_nettype none
module sdi_host_model
(
  // Link pins
  output logic LINK_CLK,
  output logic FRAME_N,
  output logic SERIAL_DATA_IN,
  input wire logic SERIAL_DATA_OUT
);
  logic [31:0] rx;
  // Idle link, clock standing high
  initial
  begin
    LINK_CLK = 1'h1;
    FRAME_N = 1'h1;
    SERIAL_DATA_IN = 1'h0;
    rx = '0;
  end
  // One frame, MSB first, 160 ns bit period
  task automatic send(input logic [31:0] w, input int n);
    #37 FRAME_N <= 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #40 SERIAL_DATA_IN <= w[i];
      #40 LINK_CLK <= 1'h0;
      #80 LINK_CLK <= 1'h1;
      rx <= {rx[30:0], SERIAL_DATA_OUT};
    end
    #80 FRAME_N <= 1'h1;
    SERIAL_DATA_IN <= ~SERIAL_DATA_IN; // Released line no longer shows data
  endtask
endmodule
`default_nettype wire

// File: test/sdi_dac_input_bench.sv
// Self-checking bench for the serial DAC input logic
`timescale 1ns/100ps
`default_nettype none
module sdi_dac_input_bench;
  import sdi_pkg::*;
  typedef struct packed {logic f; logic [15:0] w; logic [11:0] c;} sdi_row_s;
  logic CORE_CLK = 1'h0, SRST = 1'h0, CE = 1'h1, LOAD_LATCH_N = 1'h0;
  logic CHAIN_MODE_ENABLE = 1'h0, CLEAR_N = 1'h1, FORMAT_SELECT = 1'h0;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB = '0;
  logic LINK_CLK, FRAME_N, SERIAL_DATA_IN, SERIAL_DATA_OUT, SERIAL_DATA_OUT_OE_N;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic DAC_FORMAT;
  logic [11:0] DAC_CODE;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  int errors = 0, num_checks = 0;
  sdi_row_s rows [3] = '{'{1'h0, 16'hFABC, 12'hABC}, '{1'h1, 16'h0123, 12'h123},
    '{1'h0, 16'h5FFF, 12'hFFF}};
  sdi_dac_input dut (.*);
  sdi_host_model host (.*);
  // Core clock
  always #2 CORE_CLK = ~CORE_CLK;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Register write, response kept in r
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta = 1'h0;
    logic tw = 1'h0;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    while (!(ta && tw))
    begin
      @(posedge CORE_CLK);
      ta = ta || S_AXI_AWREADY;
      tw = tw || S_AXI_WREADY;
      if (ta)
        S_AXI_AWVALID <= 1'h0;
      if (tw)
        S_AXI_WVALID <= 1'h0;
    end
    do @(posedge CORE_CLK); while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
  endtask
  // Register read into d and r; lag holds off rready until data shows
  task automatic rd(input logic [7:0] a, input logic lag);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= !lag;
    do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge CORE_CLK); while (!S_AXI_RVALID);
    if (lag)
    begin
      S_AXI_RREADY <= 1'h1;
      @(posedge CORE_CLK);
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask
  // Load strobe pulse, left high for the next frame
  task automatic pulse;
    @(posedge CORE_CLK);
    LOAD_LATCH_N <= 1'h0;
    repeat (8) @(posedge CORE_CLK);
    LOAD_LATCH_N <= 1'h1;
    repeat (8) @(posedge CORE_CLK);
  endtask
  // Verdict
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    SRST <= 1'h1;
    repeat (4) @(posedge CORE_CLK);
    SRST <= 1'h0;
    repeat (10) @(posedge CORE_CLK);
    chk("reset code", CLEAR_CODE, DAC_CODE);
    chk("reset oe_n", 1, SERIAL_DATA_OUT_OE_N);
    $display("Test reset done");
    foreach (rows[i])
    begin
      FORMAT_SELECT <= rows[i].f;
      host.send(rows[i].w, 16);
      repeat (10) @(posedge CORE_CLK);
      chk("code", rows[i].c, DAC_CODE);
      chk("format", rows[i].f, DAC_FORMAT);
      rd(OFS_ZERO, 1'h0);
      chk("zero code", rows[i].f ? ZERO_TWOS : ZERO_OFFSET, d);
    end
    $display("Test auto rows done");
    host.send(32'h0A5AF, 20);
    repeat (10) @(posedge CORE_CLK);
    chk("gated code", 12'hA5A, DAC_CODE);
    LOAD_LATCH_N <= 1'h1;
    repeat (8) @(posedge CORE_CLK);
    host.send(32'h0321, 16);
    repeat (10) @(posedge CORE_CLK);
    chk("held code", 12'hA5A, DAC_CODE);
    pulse();
    chk("strobed code", 12'h321, DAC_CODE);
    $display("Test gate and strobe done");
    CLEAR_N <= 1'h0;
    repeat (10) @(posedge CORE_CLK);
    chk("clear", CLEAR_CODE, DAC_CODE);
    CLEAR_N <= 1'h1;
    CHAIN_MODE_ENABLE <= 1'h1;
    repeat (10) @(posedge CORE_CLK);
    chk("chain oe_n", 0, SERIAL_DATA_OUT_OE_N);
    host.send(32'h1234_0ABC, 32);
    pulse();
    chk("chain out", 16'h1234, host.rx[16:1]);
    chk("chain code", 12'hABC, DAC_CODE);
    $display("Test clear and chain done");
    wr(OFS_CTRL, 32'h1, 4'h0);
    chk("write resp", RESP_OKAY, r);
    rd(OFS_CTRL, 1'h0);
    chk("ctrl masked", CTRL_RST, d);
    LOAD_LATCH_N <= 1'h0;
    repeat (8) @(posedge CORE_CLK);
    wr(OFS_CTRL, 32'h1, 4'h1);
    repeat (4) @(posedge CORE_CLK);
    chk("soft clear", CLEAR_CODE, DAC_CODE);
    rd(OFS_STATUS, 1'h1);
    chk("status", (32'h1 << ST_CLR) | (32'h1 << ST_CHAIN), d);
    wr(OFS_CTRL, 32'h0, 4'h1);
    chk("release resp", RESP_OKAY, r);
    rd(OFS_COUNT, 1'h0);
    chk("update count", 32'h7, d);
    rd(8'h10, 1'h1);
    chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", '0, d);
    $display("Test registers done");
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
